// ==== design/ovp_pkg.sv ====
// shared constants and types for the overvoltage protection block
package ovp_pkg;

  // sampling: power-of-two samples per mains period
  localparam int SAMPLES_LOG2 = 4;
  localparam int SAMPLES = 1 << SAMPLES_LOG2;

  // timing base for operate and hold delays
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  // scaling
  localparam int MAG_SHIFT = 10;    // dft sum down to sample amplitude
  localparam int GAIN_SHIFT = 8;    // primary gain is unsigned 8.8
  localparam logic [15:0] PERCENT_FULL = 16'h0064;
  localparam logic [1:0] RES_SUM_FACTOR = 2'h3;  // sum of phases is 3*u0

  // register byte offsets
  localparam logic [7:0] REG_CONFIG    = 8'h00;
  localparam logic [7:0] REG_RATED     = 8'h04;
  localparam logic [7:0] REG_GAIN      = 8'h08;
  localparam logic [7:0] REG_LOWSIDE   = 8'h0C;
  localparam logic [7:0] REG_STAGE0    = 8'h10;
  localparam logic [7:0] REG_HOLD      = 8'h1C;
  localparam logic [7:0] REG_RES_THR   = 8'h20;
  localparam logic [7:0] REG_MEAS      = 8'h24;
  localparam logic [7:0] REG_STATE     = 8'h28;
  localparam logic [7:0] REG_TALLY0    = 8'h2C;
  localparam logic [7:0] REG_IRQ_STAT  = 8'h38;
  localparam logic [7:0] REG_IRQ_MASK  = 8'h3C;
  localparam logic [7:0] REG_STRIDE    = 8'h04;

  // config fields
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_EN_BIT = 2;

  // reset values
  localparam logic [31:0] CONFIG_RST = 32'h0000_0000;
  localparam logic [15:0] GAIN_RST = 16'h0100;
  localparam logic [31:0] STAGE_RST = 32'h0064_0078;  // 120 %, 100 ms

  // measurement configuration
  typedef enum logic [1:0] {
    CFG_PHASE,
    CFG_LINE,
    CFG_DELTA_RES
  } vt_config_type;

  // one cycle of cosine, scaled by 127
  localparam logic signed [7:0] COS_TABLE [SAMPLES] = '{
    8'sh7F, 8'sh75, 8'sh5A, 8'sh31, 8'sh00, -8'sh31, -8'sh5A, -8'sh75,
    -8'sh7F, -8'sh75, -8'sh5A, -8'sh31, 8'sh00, 8'sh31, 8'sh5A, 8'sh75};
  localparam logic [3:0] SIN_OFFSET = 4'hC;  // cos(x - 270 deg) = -sin(x)

endpackage

// ==== design/ov_stage.sv ====
// one definite-time overvoltage stage with optional fault hold
module ov_stage (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        tick,         // one-cycle timing base pulse
  input  wire logic        over,         // measured value above threshold
  input  wire logic        hold_on,      // stage keeps timer through gaps
  input  wire logic [15:0] delay,        // operate delay in ticks
  input  wire logic [15:0] hold_time,    // fault_hold_time in ticks
  output logic             start,
  output logic             trip,
  output logic [15:0]      pickup_tally,
  output logic [15:0]      operate_tally
);

  logic [15:0] timer;        // accumulated operate time
  logic [15:0] gap;          // time since the fault last cleared
  logic        released;     // fault gone long enough to forget it

  assign released = !hold_on || (gap >= hold_time);

  // operate timer: runs with the fault, held through short gaps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer <= '0;
    end else if (over) begin
      if (tick && timer < delay) begin
        timer <= timer + 16'h0001;
      end
    end else if (released) begin
      timer <= '0;
    end
  end

  // gap timer for the hold-capable stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap <= '0;
    end else if (over || !hold_on) begin
      gap <= '0;
    end else if (tick && gap < hold_time) begin
      gap <= gap + 16'h0001;
    end
  end

  // start follows the comparison with a fixed one-cycle delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start <= 1'b0;
    end else begin
      start <= over;
    end
  end

  // trip once the delay has fully run; drop after start and hold end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip <= 1'b0;
    end else if (over && timer >= delay) begin
      trip <= 1'b1;
    end else if (!over && released) begin
      trip <= 1'b0;
    end
  end

  // occurrence tallies, counted on rising start and trip
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pickup_tally <= '0;
      operate_tally <= '0;
    end else begin
      if (over && !start) begin
        pickup_tally <= pickup_tally + 16'h0001;
      end
      if (over && timer >= delay && !trip) begin
        operate_tally <= operate_tally + 16'h0001;
      end
    end
  end

endmodule

// ==== design/ovp_top.sv ====
// overvoltage protection: sampling, dft, scaling, three stages, apb regs
//
// Contract
// - fixed 16 samples per tracked mains period
// - three selectable measurement configurations
// - phase mode computes line voltages
// - phase mode computes residual from phases
// - stage thresholds are percent of rated
// - phase residual referenced to low side
// - line mode disables residual stages
// - delta mode measures residual, own reference
// - three stages, own threshold and delay
// - fundamental only, maximum line voltage
// - definite time operate delay
// - start when measured exceeds threshold
// - trip after delay fully elapsed
// - start delay fixed, not settable
// - first stage holds timer until release
// - first stage: fault return resumes accumulated time
// - readable start and trip tallies
// - report max line voltage, primary
module ovp_top #(
  parameter int TICK_DIV = ovp_pkg::TICK_CYCLES  // cycles per timing tick
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic [7:0]         paddr,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               mains_zero_cross,  // rising at period start
  input  wire logic signed [15:0] adc_a,             // channel 1 converted
  input  wire logic signed [15:0] adc_b,
  input  wire logic signed [15:0] adc_c,
  input  wire logic signed [15:0] adc_r,             // residual channel
  output logic                    sample_strobe,     // take a sample now
  output logic [2:0]              start,
  output logic [2:0]              trip,
  output logic                    residual_over,
  output logic                    irq
);

  localparam int NCH = 4;  // three line channels and the residual

  // software registers
  logic [31:0] config_reg;
  logic [15:0] rated_line_voltage;   // primary volts
  logic [15:0] primary_gain;         // adc counts to primary volts
  logic [15:0] transformer_low_side_voltage;
  logic [15:0] residual_transformer_low_side_voltage;
  logic [31:0] stage_cfg [3];        // threshold pct low, delay high
  logic [15:0] fault_hold_time;
  logic [15:0] res_thr;              // residual threshold pct
  logic [5:0]  irq_status;           // start rises, then trip rises
  logic [5:0]  irq_mask;

  // measurement path
  ovp_pkg::vt_config_type mode;
  logic        enable;
  logic [23:0] period_cnt;           // cycles since last zero cross
  logic [23:0] period;               // last measured mains period
  logic [23:0] interval_cnt;
  logic        zc_prev;
  logic        zc_rise;
  logic [3:0]  sample_idx;
  logic signed [17:0] samp [NCH];
  logic signed [31:0] acc_re [NCH];
  logic signed [31:0] acc_im [NCH];
  logic [15:0] mag [NCH];            // fundamental amplitude per channel
  logic [15:0] max_line;
  logic [31:0] meas_primary;
  logic [2:0]  over;
  logic [16:0] tick_cnt;
  logic        tick;
  logic [15:0] pickup_tally [3];
  logic [15:0] operate_tally [3];
  logic [2:0]  start_d;
  logic [2:0]  trip_d;
  logic [5:0]  events;

  // apb decode
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic [31:0] rd_mux;

  assign enable = config_reg[ovp_pkg::CFG_EN_BIT];
  assign zc_rise = mains_zero_cross && !zc_prev;

  // magnitude estimate: larger part plus half the smaller
  function automatic logic [31:0] mag_est(input logic signed [31:0] re,
                                          input logic signed [31:0] im);
    logic [31:0] ar;
    logic [31:0] ai;
    ar = re[31] ? 32'(-re) : 32'(re);
    ai = im[31] ? 32'(-im) : 32'(im);
    mag_est = (ar > ai) ? ar + (ai >> 1) : ai + (ar >> 1);
  endfunction

  // unknown codes fall back to the phase configuration
  always_comb begin
    case (config_reg[ovp_pkg::CFG_MODE_LSB +: 2])
      2'h1:    mode = ovp_pkg::CFG_LINE;
      2'h2:    mode = ovp_pkg::CFG_DELTA_RES;
      default: mode = ovp_pkg::CFG_PHASE;
    endcase
  end

  // one-millisecond timing base
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (tick_cnt == 17'(TICK_DIV - 1)) begin
      tick_cnt <= '0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 17'h00001;
      tick <= 1'b0;
    end
  end

  // mains period tracking from the zero-cross comparator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zc_prev <= 1'b0;
      period_cnt <= '0;
      period <= '0;
    end else begin
      zc_prev <= mains_zero_cross;
      if (zc_rise) begin
        period <= period_cnt + 24'h000001;
        period_cnt <= '0;
      end else if (period_cnt != '1) begin
        period_cnt <= period_cnt + 24'h000001;
      end
    end
  end

  // sample clock: period split into a fixed power-of-two count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interval_cnt <= '0;
      sample_strobe <= 1'b0;
    end else if (zc_rise ||
                 interval_cnt >= (period >> ovp_pkg::SAMPLES_LOG2) - 24'h000001) begin
      interval_cnt <= '0;
      sample_strobe <= (period != '0);
    end else begin
      interval_cnt <= interval_cnt + 24'h000001;
      sample_strobe <= 1'b0;
    end
  end

  // form line and residual samples from the inputs per configuration
  always_comb begin
    case (mode)
      ovp_pkg::CFG_LINE: begin
        samp[0] = 18'(adc_a);
        samp[1] = 18'(adc_b);
        samp[2] = 18'(adc_c);
        samp[3] = '0;
      end
      ovp_pkg::CFG_DELTA_RES: begin
        samp[0] = 18'(adc_a);
        samp[1] = 18'(adc_b);
        samp[2] = -(18'(adc_a) + 18'(adc_b));
        samp[3] = 18'(adc_r);
      end
      default: begin
        samp[0] = 18'(adc_a) - 18'(adc_b);
        samp[1] = 18'(adc_b) - 18'(adc_c);
        samp[2] = 18'(adc_c) - 18'(adc_a);
        samp[3] = 18'(adc_a) + 18'(adc_b) + 18'(adc_c);
      end
    endcase
  end

  // single-bin dft over one period keeps only the fundamental
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_idx <= '0;
      for (int k = 0; k < NCH; k++) begin
        acc_re[k] <= '0;
        acc_im[k] <= '0;
        mag[k] <= '0;
      end
    end else if (zc_rise) begin
      sample_idx <= '0;  // realign the window to the period start
    end else if (sample_strobe) begin
      sample_idx <= sample_idx + 4'h1;
      for (int k = 0; k < NCH; k++) begin
        if (sample_idx == '0) begin
          acc_re[k] <= 32'(samp[k] * ovp_pkg::COS_TABLE[sample_idx]);
          acc_im[k] <= 32'(samp[k] *
                           ovp_pkg::COS_TABLE[sample_idx - ovp_pkg::SIN_OFFSET]);
        end else begin
          acc_re[k] <= acc_re[k] + 32'(samp[k] * ovp_pkg::COS_TABLE[sample_idx]);
          acc_im[k] <= acc_im[k] +
                       32'(samp[k] * ovp_pkg::COS_TABLE[sample_idx - ovp_pkg::SIN_OFFSET]);
        end
        if (sample_idx == '0) begin  // last period complete
          mag[k] <= 16'(mag_est(acc_re[k], acc_im[k]) >> ovp_pkg::MAG_SHIFT);
        end
      end
    end
  end

  // largest line voltage, converted to primary volts
  always_comb begin
    max_line = mag[0];
    if (mag[1] > max_line) max_line = mag[1];
    if (mag[2] > max_line) max_line = mag[2];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_primary <= '0;
    end else begin
      meas_primary <= (32'(max_line) * 32'(primary_gain)) >> ovp_pkg::GAIN_SHIFT;
    end
  end

  // stage compare in percent of rated line voltage, residual compare in percent of low side voltage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      over <= '0;
      residual_over <= 1'b0;
    end else begin
      for (int n = 0; n < 3; n++) begin
        over[n] <= enable && (48'(meas_primary) * 48'(ovp_pkg::PERCENT_FULL) >
                   48'(stage_cfg[n][15:0]) * 48'(rated_line_voltage));
      end
      case (mode)
        ovp_pkg::CFG_LINE: residual_over <= 1'b0;
        ovp_pkg::CFG_DELTA_RES:
          residual_over <= enable && (40'(mag[3]) * 40'(ovp_pkg::PERCENT_FULL) >
            40'(res_thr) * 40'(residual_transformer_low_side_voltage));
        default:
          residual_over <= enable && (40'(mag[3]) * 40'(ovp_pkg::PERCENT_FULL) >
            40'(res_thr) * 40'(transformer_low_side_voltage) * 40'(ovp_pkg::RES_SUM_FACTOR));
      endcase
    end
  end

  // the three stages; only the first one holds its timer through gaps
  for (genvar n = 0; n < 3; n++) begin : g_stage
    ov_stage u_stage (
      .pclk          (pclk),
      .presetn       (presetn),
      .tick          (tick),
      .over          (over[n]),
      .hold_on       (n == 0),
      .delay         (stage_cfg[n][31:16]),
      .hold_time     (fault_hold_time),
      .start         (start[n]),
      .trip          (trip[n]),
      .pickup_tally  (pickup_tally[n]),
      .operate_tally (operate_tally[n])
    );
  end

  // rising edges of start and trip become interrupt events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_d <= '0;
      trip_d <= '0;
    end else begin
      start_d <= start;
      trip_d <= trip;
    end
  end

  assign events = {trip & ~trip_d, start & ~start_d};

  // apb: zero wait states, unmapped offsets answer with an error
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !pwrite;
  assign pready = 1'b1;

  always_comb begin
    addr_ok = 1'b1;
    rd_mux = '0;
    case (paddr)
      ovp_pkg::REG_CONFIG:   rd_mux = config_reg;
      ovp_pkg::REG_RATED:    rd_mux = 32'(rated_line_voltage);
      ovp_pkg::REG_GAIN:     rd_mux = 32'(primary_gain);
      ovp_pkg::REG_LOWSIDE:
        rd_mux = {residual_transformer_low_side_voltage, transformer_low_side_voltage};
      ovp_pkg::REG_STAGE0:   rd_mux = stage_cfg[0];
      ovp_pkg::REG_STAGE0 + ovp_pkg::REG_STRIDE:     rd_mux = stage_cfg[1];
      ovp_pkg::REG_STAGE0 + 2 * ovp_pkg::REG_STRIDE: rd_mux = stage_cfg[2];
      ovp_pkg::REG_HOLD:     rd_mux = 32'(fault_hold_time);
      ovp_pkg::REG_RES_THR:  rd_mux = 32'(res_thr);
      ovp_pkg::REG_MEAS:     rd_mux = meas_primary;
      ovp_pkg::REG_STATE:    rd_mux = {24'h000000, 1'b0, residual_over, trip, start};
      ovp_pkg::REG_TALLY0:   rd_mux = {operate_tally[0], pickup_tally[0]};
      ovp_pkg::REG_TALLY0 + ovp_pkg::REG_STRIDE:
        rd_mux = {operate_tally[1], pickup_tally[1]};
      ovp_pkg::REG_TALLY0 + 2 * ovp_pkg::REG_STRIDE:
        rd_mux = {operate_tally[2], pickup_tally[2]};
      ovp_pkg::REG_IRQ_STAT: rd_mux = 32'(irq_status);
      ovp_pkg::REG_IRQ_MASK: rd_mux = 32'(irq_mask);
      default:               addr_ok = 1'b0;
    endcase
  end

  // read data and error are registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= rd_en ? rd_mux : 32'h0000_0000;
      pslverr <= !addr_ok;
    end
  end

  // configuration writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_reg <= ovp_pkg::CONFIG_RST;
      rated_line_voltage <= '0;
      primary_gain <= ovp_pkg::GAIN_RST;
      transformer_low_side_voltage <= '0;
      residual_transformer_low_side_voltage <= '0;
      stage_cfg[0] <= ovp_pkg::STAGE_RST;
      stage_cfg[1] <= ovp_pkg::STAGE_RST;
      stage_cfg[2] <= ovp_pkg::STAGE_RST;
      fault_hold_time <= '0;
      res_thr <= '0;
      irq_mask <= '0;
    end else if (wr_en) begin
      case (paddr)
        ovp_pkg::REG_CONFIG:  config_reg <= pwdata;
        ovp_pkg::REG_RATED:   rated_line_voltage <= pwdata[15:0];
        ovp_pkg::REG_GAIN:    primary_gain <= pwdata[15:0];
        ovp_pkg::REG_LOWSIDE: begin
          transformer_low_side_voltage <= pwdata[15:0];
          residual_transformer_low_side_voltage <= pwdata[31:16];
        end
        ovp_pkg::REG_STAGE0:  stage_cfg[0] <= pwdata;
        ovp_pkg::REG_STAGE0 + ovp_pkg::REG_STRIDE:     stage_cfg[1] <= pwdata;
        ovp_pkg::REG_STAGE0 + 2 * ovp_pkg::REG_STRIDE: stage_cfg[2] <= pwdata;
        ovp_pkg::REG_HOLD:    fault_hold_time <= pwdata[15:0];
        ovp_pkg::REG_RES_THR: res_thr <= pwdata[15:0];
        ovp_pkg::REG_IRQ_MASK: irq_mask <= pwdata[5:0];
        default: ;  // read-only, unmapped or irq status (cleared below): write not stored here
      endcase
    end
  end

  // sticky status: a new event wins over a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
    end else if (wr_en && paddr == ovp_pkg::REG_IRQ_STAT) begin
      irq_status <= (irq_status & ~pwdata[5:0]) | events;
    end else begin
      irq_status <= irq_status | events;
    end
  end

  assign irq = |(irq_status & irq_mask);

endmodule

// ==== sim/ovp_top_chk.sv ====
// port-level assertions for the overvoltage protection block
module ovp_top_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        mains_zero_cross,
  input wire logic        sample_strobe,
  input wire logic [2:0]  start,
  input wire logic [2:0]  trip
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] strobe_cnt;  // strobes since the last period start
  logic [1:0] rises;       // period starts seen, saturating

  // strobes per period; first periods skipped while tracking settles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_cnt <= 5'h00;
      rises      <= 2'h0;
    end else if ($rose(mains_zero_cross)) begin
      strobe_cnt <= {4'h0, sample_strobe};
      rises      <= (rises == 2'h3) ? rises : rises + 2'h1;
    end else begin
      strobe_cnt <= strobe_cnt + {4'h0, sample_strobe};
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pready_high: assert property (pready)
    else $error("pready low");
  a_unmapped_err: assert property (
    psel && !penable && paddr > 8'h3C |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (
    psel && !penable && paddr <= 8'h3C && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped access refused");
  a_strobe_pulse: assert property (sample_strobe |=> !sample_strobe)
    else $error("sample strobe longer than one cycle");
  a_strobe_count: assert property (
    $rose(mains_zero_cross) && rises == 2'h3 |-> strobe_cnt == 5'h10)
    else $error("samples per period not sixteen");
  a_trip_needs_start: assert property ((trip & ~$past(trip) & ~start) == 3'h0)
    else $error("trip rose without start");
  a_stage1_release: assert property ($fell(start[1]) |-> ##[0:2] !trip[1])
    else $error("stage 1 trip outlived start");
  a_stage2_release: assert property ($fell(start[2]) |-> ##[0:2] !trip[2])
    else $error("stage 2 trip outlived start");
endmodule

// ==== sim/vt_source.sv ====
// transformer model: steady mains period, cosine samples on channels a and r
module vt_source #(
  parameter int PERIOD = 160  // clock cycles per mains period
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic signed [15:0] amp_a,  // peak of channel a
  input  wire logic signed [15:0] amp_r,  // peak of residual channel
  output logic                    mains_zero_cross,
  output logic signed [15:0]      adc_a,
  output logic signed [15:0]      adc_b,
  output logic signed [15:0]      adc_c,
  output logic signed [15:0]      adc_r
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pcnt;  // position in the mains period
  logic [3:0] idx;   // sample slot of the waveform

  function automatic logic signed [15:0] wave(input logic signed [15:0] amp,
                                              input logic [3:0] i);
    int p;
    p = int'(amp) * int'(ovp_pkg::COS_TABLE[i]);
    return 16'(p / 127);
  endfunction

  // free-running period counter at a fixed period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcnt <= 8'h00;
    end else begin
      pcnt <= (pcnt == 8'(PERIOD - 1)) ? 8'h00 : pcnt + 8'h01;
    end
  end

  assign idx              = 4'(int'(pcnt) / (PERIOD / 16));
  assign mains_zero_cross = (int'(pcnt) < PERIOD / 2);
  // b and c stay zero: lines a-b and c-a both carry amp_a
  assign adc_a            = wave(amp_a, idx);
  assign adc_b            = 16'sh0000;
  assign adc_c            = 16'sh0000;
  assign adc_r            = wave(amp_r, idx);
endmodule

// ==== sim/ovp_top_tb_top.sv ====
// self-checking testbench for the overvoltage protection block
module ovp_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 10;  // cycles per timing tick, shortened from 1 ms
  logic               pclk;
  logic               presetn;
  logic [7:0]         paddr;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               mains_zero_cross;
  logic signed [15:0] adc_a, adc_b, adc_c, adc_r;
  logic signed [15:0] amp_a, amp_r;  // stimulus amplitudes for the model
  logic               sample_strobe;
  logic [2:0]         start, trip;
  logic               residual_over, irq;
  int                 fails, n_tests, n;
  logic [31:0]        rd;
  logic               err;

  ovp_top #(.TICK_DIV(TICK)) ovp_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mains_zero_cross(mains_zero_cross),
    .adc_a(adc_a), .adc_b(adc_b), .adc_c(adc_c), .adc_r(adc_r),
    .sample_strobe(sample_strobe), .start(start), .trip(trip),
    .residual_over(residual_over), .irq(irq));
  vt_source vt_source_i (.pclk(pclk), .presetn(presetn), .amp_a(amp_a), .amp_r(amp_r),
    .mains_zero_cross(mains_zero_cross), .adc_a(adc_a), .adc_b(adc_b), .adc_c(adc_c),
    .adc_r(adc_r));

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer: setup, then access until pready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      fails++;
      results();
    end
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    check(what, rd, exp);
  endtask

  // bounded wait on a start or trip bit; n counts cycles
  task automatic wait_out(input bit is_trip, input int k, input logic v, input int lim);
    n = 0;
    while (((is_trip ? trip[k] : start[k]) !== v) && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (n >= lim) begin
      fails++;
      results();
    end
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // watchdog: a hang ends the run as a failure
  initial begin
    repeat (60000) @(posedge pclk);
    fails++;
    results();
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0000_0000; amp_a = 16'sh0000; amp_r = 16'sh0000; fails = 0; n_tests = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and refused access
    rd_chk("config", ovp_pkg::REG_CONFIG, ovp_pkg::CONFIG_RST);
    rd_chk("gain", ovp_pkg::REG_GAIN, {16'h0000, ovp_pkg::GAIN_RST});
    for (int i = 0; i < 3; i++) rd_chk("stage", ovp_pkg::REG_STAGE0 + 8'(4 * i), ovp_pkg::STAGE_RST);
    rd_chk("hold", ovp_pkg::REG_HOLD, 32'h0000_0000);
    xfer(1'b0, 8'h40, 32'h0000_0000);
    check("unmapped", {rd[30:0], err}, 32'h0000_0001);
    // rated 1000 V; stages 120 %/20, 150 %/5, 160 %/3 ticks; residual 50 %
    xfer(1'b1, ovp_pkg::REG_RATED, 32'h0000_03E8);
    xfer(1'b1, ovp_pkg::REG_STAGE0, 32'h0014_0078);
    xfer(1'b1, ovp_pkg::REG_STAGE0 + 8'h04, 32'h0005_0096);
    xfer(1'b1, ovp_pkg::REG_STAGE0 + 8'h08, 32'h0003_00A0);
    xfer(1'b1, ovp_pkg::REG_LOWSIDE, 32'h03E8_03E8);
    xfer(1'b1, ovp_pkg::REG_RES_THR, 32'h0000_0032);
    xfer(1'b1, ovp_pkg::REG_IRQ_MASK, 32'h0000_003F);
    xfer(1'b1, ovp_pkg::REG_CONFIG, 32'h0000_0004);
    // 1300 V: only the lowest stage picks up, trip after its own delay
    amp_a <= 16'sh0514;
    wait_out(1'b0, 0, 1'b1, 800);
    check("start0 up", 32'(n < 800), 32'h1);
    wait_out(1'b1, 0, 1'b1, 400);
    check("trip0 delay", 32'(n >= 185 && n <= 215), 32'h1);
    check("start hi", {29'h0, start[2:1], residual_over}, 32'h0);
    rd_chk("state", ovp_pkg::REG_STATE, 32'h0000_0009);
    xfer(1'b0, ovp_pkg::REG_MEAS, 32'h0);
    check("meas range", 32'(rd >= 32'd1280 && rd <= 32'd1450), 32'h1);
    check("irq", 32'(irq), 32'h1);
    // 2000 V: stages 1 and 2 and the phase residual pick up too
    amp_a <= 16'sh07D0;
    wait_out(1'b0, 1, 1'b1, 800);
    wait_out(1'b1, 1, 1'b1, 200);
    check("trip1 delay", 32'(n >= 35 && n <= 65), 32'h1);
    wait_out(1'b1, 2, 1'b1, 200);
    check("trip2", 32'(n < 200), 32'h1);
    check("residual", 32'(residual_over), 32'h1);
    for (int i = 0; i < 3; i++) rd_chk("tally", ovp_pkg::REG_TALLY0 + 8'(4 * i), 32'h0001_0001);
    rd_chk("status", ovp_pkg::REG_IRQ_STAT, 32'h0000_003F);
    xfer(1'b1, ovp_pkg::REG_IRQ_MASK, 32'h0000_0000);
    @(posedge pclk);
    check("irq masked", 32'(irq), 32'h0);
    xfer(1'b1, ovp_pkg::REG_IRQ_MASK, 32'h0000_003F);
    xfer(1'b1, ovp_pkg::REG_IRQ_STAT, 32'h0000_003F);
    @(posedge pclk);
    check("irq cleared", 32'(irq), 32'h0);
    // fault gone: all stages release, no hold configured
    amp_a <= 16'sh0000;
    wait_out(1'b0, 0, 1'b0, 800);
    repeat (3) @(posedge pclk);
    check("released", {26'h0, start, trip}, 32'h0);
    // intermittent fault on stage 0: delay 150 ticks, hold 100 ticks
    xfer(1'b1, ovp_pkg::REG_STAGE0, 32'h0096_0078);
    xfer(1'b1, ovp_pkg::REG_HOLD, 32'h0000_0064);
    amp_a <= 16'sh0514;
    repeat (1000) @(posedge pclk);
    amp_a <= 16'sh0000;
    repeat (500) @(posedge pclk);
    check("no early trip", 32'(trip[0]), 32'h0);
    amp_a <= 16'sh0514;
    wait_out(1'b1, 0, 1'b1, 1100);
    check("resumed", 32'(n < 1100), 32'h1);
    amp_a <= 16'sh0000;
    wait_out(1'b0, 0, 1'b0, 800);
    repeat (500) @(posedge pclk);
    check("trip held", 32'(trip[0]), 32'h1);
    wait_out(1'b1, 0, 1'b0, 800);
    check("hold ends", 32'(n < 800), 32'h1);
    // line mode ignores residual, delta mode uses it
    amp_r <= 16'sh0BB8;
    xfer(1'b1, ovp_pkg::REG_CONFIG, 32'h0000_0005);
    repeat (500) @(posedge pclk);
    check("line residual", 32'(residual_over), 32'h0);
    xfer(1'b1, ovp_pkg::REG_CONFIG, 32'h0000_0006);
    repeat (500) @(posedge pclk);
    check("delta residual", 32'(residual_over), 32'h1);
    results();
  end
endmodule

bind ovp_top ovp_top_chk ovp_top_chk_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .mains_zero_cross(mains_zero_cross), .sample_strobe(sample_strobe), .start(start),
  .trip(trip));
